// ---- rtl/sbp_param_regs.sv ----
/*
  Parameter register bank for the binarization and enhancement path:
  host register file, decoded controls, background tracker and the
  spare line-memory address pin.
  Assumes a synchronous host port on mclk and a pixel stream on mclk.
*/
// Functional notes
// - black speed zero stops dark tracking; larger values adapt faster
// - white speed zero stops light tracking; larger values adapt faster
// - mode 00/01 threshold, 10 ordered dither, 11 error diffusion
// - parameter is slice level, black level in diffusion, ignored in dither
// - edge strength zero is off, one to fifteen increasingly strong
// - edge correction value is the edge versus smoothing threshold
// - smoothing zero off, one to six stronger; host never writes seven
// - character B is the combined density threshold in halftoning
// - character A zero off, higher codes stronger, only in halftoning
// - expansion enable takes the top line-memory address pin over
// - expansion pin follows the expansion data bit
// - device reset clears registers 0 to 2 and back register only
// - clamp start and end positions count single pixels
// - distortion start position counts single pixels
// - tracker start and end positions count sixteen-pixel steps
// - address 8 is the data port for adc and line memories
module sbp_param_regs
(
  // clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic dev_reset,
  // host register port
  input wire logic [3:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata,
  // data port sources and strobes
  input wire logic [7:0] adc_data,
  input wire logic [7:0] int_mem_rdata,
  input wire logic [7:0] ext_mem_rdata,
  output logic [7:0] mem_wdata,
  output logic int_mem_we,
  output logic ext_mem_we,
  output logic int_mem_re,
  output logic ext_mem_re,
  output logic adc_re,
  // pixel stream
  input wire logic pix_valid,
  input wire logic [5:0] pix_level,
  input wire logic [11:0] pix_count,
  input wire logic line_mem_addr_msb,
  // raw configuration
  output logic [7:0] ctrl0,
  output logic [7:0] ctrl1,
  output logic [7:0] ctrl2,
  output logic [7:0] reduce_num,
  output logic [7:0] reduce_den,
  output logic [7:0] dac_data,
  // decoded controls
  output logic mode_threshold,
  output logic mode_dither,
  output logic mode_diffusion,
  output logic [5:0] slice_level,
  output logic [5:0] black_level,
  output logic [3:0] edge_h_strength,
  output logic [3:0] edge_v_strength,
  output logic [4:0] edge_corr_thr,
  output logic [2:0] smooth_degree,
  output logic [3:0] char_b_thr,
  output logic [2:0] char_a_strength,
  output logic applied_binary,
  output logic all_addr_access,
  // windows, tracker and expansion pin
  output logic clamp_window,
  output logic distort_active,
  output logic abc_window,
  output logic [5:0] bg_level,
  output logic line_mem_addr_top_bit
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0][7:0] regs;
    logic [7:0] back;
    logic [7:0] rdata;
    logic thr;
    logic dith;
    logic diff;
    logic [5:0] slice;
    logic [5:0] blk;
    logic [3:0] edge_h;
    logic [3:0] edge_v;
    logic [4:0] corr;
    logic [2:0] smooth;
    logic [3:0] char_b;
    logic [2:0] char_a;
    logic clamp_win;
    logic dist_act;
    logic abc_win;
    logic [5:0] bg;
    logic [4:0] acc_dark;
    logic [4:0] acc_light;
    logic top_bit;
  } sbp_state_t;

  sbp_state_t st;
  sbp_state_t next_st;

  logic port_wr;
  logic port_rd;
  logic back_sel;
  logic [11:0] abc_lo;
  logic [11:0] abc_hi;
  logic [5:0] sum_dark;
  logic [5:0] sum_light;

  // the data port register is shadowed by the memory path when writes are on
  assign port_wr = cpu_wr && (cpu_addr == sbp_pkg::REG_DATA_PORT);
  assign port_rd = cpu_rd && (cpu_addr == sbp_pkg::REG_DATA_PORT);
  assign back_sel = st.regs[sbp_pkg::REG_CTRL2][sbp_pkg::CTRL2_BACK_EN];
  assign abc_lo = 12'(st.regs[sbp_pkg::REG_ABC_START]) << sbp_pkg::ABC_UNIT_SHIFT;
  assign abc_hi = 12'(st.regs[sbp_pkg::REG_ABC_END]) << sbp_pkg::ABC_UNIT_SHIFT;
  assign sum_dark = {2'h0, st.regs[sbp_pkg::REG_TRACK_SPEED][3:0]} + {1'b0, st.acc_dark};
  assign sum_light = {2'h0, st.regs[sbp_pkg::REG_TRACK_SPEED][7:4]} + {1'b0, st.acc_light};

  // ****************************************************************
  // data port router
  // ****************************************************************
  sbp_port_router u_router
  (
    .mclk(mclk),
    .rst(rst),
    .port_wr(port_wr),
    .port_rd(port_rd),
    .port_wdata(cpu_wdata),
    .sram_sel(st.regs[sbp_pkg::REG_CTRL0][sbp_pkg::CTRL0_SRAM_SEL]),
    .wr_en(st.regs[sbp_pkg::REG_CTRL0][sbp_pkg::CTRL0_WR_EN]),
    .rd_en(st.regs[sbp_pkg::REG_CTRL0][sbp_pkg::CTRL0_RD_EN]),
    .mem_wdata_q(),
    .mem_wdata(mem_wdata),
    .int_mem_we(int_mem_we),
    .ext_mem_we(ext_mem_we),
    .int_mem_re(int_mem_re),
    .ext_mem_re(ext_mem_re),
    .adc_re(adc_re)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    next_st = st;

    // host writes; address 8 stores the numerator only while memory writes are off
    if (cpu_wr)
    begin
      if (cpu_addr == sbp_pkg::REG_DAC && back_sel)
        next_st.back = {cpu_wdata[7:5], 5'h00};
      else if (!(port_wr && st.regs[sbp_pkg::REG_CTRL0][sbp_pkg::CTRL0_WR_EN]))
        next_st.regs[cpu_addr] = cpu_wdata;
    end

    // device reset clears the run controls and the back register only
    if (dev_reset)
    begin
      next_st.regs[sbp_pkg::REG_CTRL0] = sbp_pkg::REG_RESET;
      next_st.regs[sbp_pkg::REG_CTRL1] = sbp_pkg::REG_RESET;
      next_st.regs[sbp_pkg::REG_CTRL2] = sbp_pkg::REG_RESET;
      next_st.back = sbp_pkg::REG_RESET;
    end

    // read data: control 0 and the data port are the readable addresses
    if (cpu_rd && cpu_addr == sbp_pkg::REG_CTRL0)
      next_st.rdata = st.regs[sbp_pkg::REG_CTRL0];
    else if (port_rd)
    begin
      if (!st.regs[sbp_pkg::REG_CTRL0][sbp_pkg::CTRL0_RD_EN])
        next_st.rdata = adc_data;
      else if (st.regs[sbp_pkg::REG_CTRL0][sbp_pkg::CTRL0_SRAM_SEL])
        next_st.rdata = int_mem_rdata;
      else
        next_st.rdata = ext_mem_rdata;
    end
    else if (cpu_rd)
      next_st.rdata = 8'h00; // write-only addresses read as zero

    // binary mode decode
    next_st.thr = !st.regs[sbp_pkg::REG_BINARY][7];
    next_st.dith = st.regs[sbp_pkg::REG_BINARY][7:6] == sbp_pkg::MODE_DITHER;
    next_st.diff = st.regs[sbp_pkg::REG_BINARY][7:6] == sbp_pkg::MODE_DIFFUSION;

    // parameter meaning follows the mode; dither leaves both at zero
    next_st.slice = next_st.thr ? st.regs[sbp_pkg::REG_BINARY][5:0] : 6'h00;
    next_st.blk = next_st.diff ? st.regs[sbp_pkg::REG_BINARY][5:0] : 6'h00;

    // edge strengths pass as-is: zero is off, higher is stronger
    next_st.edge_h = st.regs[sbp_pkg::REG_EDGE][7:4];
    next_st.edge_v = st.regs[sbp_pkg::REG_EDGE][3:0];
    next_st.corr = st.regs[sbp_pkg::REG_SMOOTH][4:0];

    // the forbidden smoothing code is held at the strongest legal level
    if (st.regs[sbp_pkg::REG_SMOOTH][7:5] > sbp_pkg::SMOOTH_MAX)
      next_st.smooth = sbp_pkg::SMOOTH_MAX;
    else
      next_st.smooth = st.regs[sbp_pkg::REG_SMOOTH][7:5];

    // character enhancement only acts while halftoning
    next_st.char_b = (next_st.dith || next_st.diff) ? st.regs[sbp_pkg::REG_CHAR][3:0] : 4'h0;
    next_st.char_a = (next_st.dith || next_st.diff) ? st.regs[sbp_pkg::REG_CHAR][6:4] : 3'h0;

    // position windows against the running pixel count
    next_st.clamp_win = (pix_count >= {4'h0, st.regs[sbp_pkg::REG_CLAMP_START]})
      && (pix_count <= {4'h0, st.regs[sbp_pkg::REG_CLAMP_END]});
    next_st.dist_act = pix_count >= {4'h0, st.regs[sbp_pkg::REG_DISTORT_START]};
    next_st.abc_win = (pix_count >= abc_lo) && (pix_count < abc_hi);

    // tracker: speed is added to a 5-bit phase, each carry moves the level one step
    if (pix_valid && st.abc_win)
    begin
      if (pix_level < st.bg)
      begin
        next_st.acc_dark = sum_dark[4:0];
        if (sum_dark[5])
          next_st.bg = st.bg - 6'h01;
      end
      else if (pix_level > st.bg)
      begin
        next_st.acc_light = sum_light[4:0];
        if (sum_light[5])
          next_st.bg = st.bg + 6'h01;
      end
    end

    // spare address pin: expansion data replaces the address bit
    if (next_st.back[sbp_pkg::BACK_EXP_EN])
      next_st.top_bit = next_st.back[sbp_pkg::BACK_EXP_DATA];
    else
      next_st.top_bit = line_mem_addr_msb;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // async reset puts everything at a known value; dev_reset is the selective one
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.bg <= sbp_pkg::BG_RESET;
    end
    else
      st <= next_st;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign cpu_rdata = st.rdata;
  assign ctrl0 = st.regs[sbp_pkg::REG_CTRL0];
  assign ctrl1 = st.regs[sbp_pkg::REG_CTRL1];
  assign ctrl2 = st.regs[sbp_pkg::REG_CTRL2];
  assign reduce_num = st.regs[sbp_pkg::REG_DATA_PORT];
  assign reduce_den = st.regs[sbp_pkg::REG_REDUCE_DEN];
  assign dac_data = st.regs[sbp_pkg::REG_DAC];
  assign mode_threshold = st.thr;
  assign mode_dither = st.dith;
  assign mode_diffusion = st.diff;
  assign slice_level = st.slice;
  assign black_level = st.blk;
  assign edge_h_strength = st.edge_h;
  assign edge_v_strength = st.edge_v;
  assign edge_corr_thr = st.corr;
  assign smooth_degree = st.smooth;
  assign char_b_thr = st.char_b;
  assign char_a_strength = st.char_a;
  assign applied_binary = st.regs[sbp_pkg::REG_CHAR][sbp_pkg::CHAR_APPLIED];
  assign all_addr_access = st.back[sbp_pkg::BACK_ALL_ADDR];
  assign clamp_window = st.clamp_win;
  assign distort_active = st.dist_act;
  assign abc_window = st.abc_win;
  assign bg_level = st.bg;
  assign line_mem_addr_top_bit = st.top_bit;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_write(logic [3:0] a, logic [7:0] d);
    cpu_wr && cpu_addr == a && cpu_wdata == d && !dev_reset;
  endsequence

  sequence s_settle;
    !cpu_wr && !dev_reset ##1 !cpu_wr && !dev_reset;
  endsequence

  a_dark_hold: assert property (@(posedge mclk) disable iff (rst)
    st.bg < $past(st.bg) |-> $past(st.regs[sbp_pkg::REG_TRACK_SPEED][3:0]) != 4'h0)
    else $error("tracker fell with black speed zero");

  a_light_hold: assert property (@(posedge mclk) disable iff (rst)
    st.bg > $past(st.bg) |-> $past(st.regs[sbp_pkg::REG_TRACK_SPEED][7:4]) != 4'h0)
    else $error("tracker rose with white speed zero");

  a_dither_mode: assert property (@(posedge mclk) disable iff (rst)
    s_write(sbp_pkg::REG_BINARY, 8'hA5) ##1 s_settle |-> mode_dither && !mode_threshold)
    else $error("dither mode not decoded");

  a_param_use: assert property (@(posedge mclk) disable iff (rst)
    s_write(sbp_pkg::REG_BINARY, 8'hE7) ##1 s_settle |-> black_level == 6'h27 && slice_level == 6'h00)
    else $error("binary parameter misrouted");

  a_edge_off: assert property (@(posedge mclk) disable iff (rst)
    s_write(sbp_pkg::REG_EDGE, 8'h00) ##1 s_settle |-> edge_h_strength == 4'h0 && edge_v_strength == 4'h0)
    else $error("edge enhancement not off");

  a_smooth_cap: assert property (@(posedge mclk) disable iff (rst)
    smooth_degree != 3'h7)
    else $error("smoothing code seven reached output");

  a_char_gate: assert property (@(posedge mclk) disable iff (rst)
    mode_threshold |-> char_a_strength == 3'h0 && char_b_thr == 4'h0)
    else $error("character enhancement active in threshold mode");

  a_exp_pin: assert property (@(posedge mclk) disable iff (rst)
    st.back[sbp_pkg::BACK_EXP_EN] |-> line_mem_addr_top_bit == st.back[sbp_pkg::BACK_EXP_DATA])
    else $error("expansion pin does not follow data bit");

  a_dev_reset: assert property (@(posedge mclk) disable iff (rst)
    dev_reset |=> ctrl0 == 8'h00 && st.back == 8'h00
      && st.regs[sbp_pkg::REG_BINARY] == $past(st.regs[sbp_pkg::REG_BINARY]))
    else $error("device reset scope wrong");

  a_port_write: assert property (@(posedge mclk) disable iff (rst)
    port_wr && ctrl0[sbp_pkg::CTRL0_WR_EN] |=> (int_mem_we ^ ext_mem_we)
      && reduce_num == $past(reduce_num))
    else $error("data port write not routed");

  // the pin registers the sequencer bit, so it is compared with that bit from one cycle earlier
  a_pin_passthru: assert property (@(posedge mclk) disable iff (rst)
    !st.back[sbp_pkg::BACK_EXP_EN] && !$past(rst)
      |-> line_mem_addr_top_bit == $past(line_mem_addr_msb))
    else $error("address pin does not follow sequencer bit");

  a_adc_read: assert property (@(posedge mclk) disable iff (rst)
    port_rd && !ctrl0[sbp_pkg::CTRL0_RD_EN] |=> cpu_rdata == $past(adc_data))
    else $error("data port read did not return adc result");

  a_dist_units: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) |-> distort_active
      == ($past(pix_count) >= 12'($past(st.regs[sbp_pkg::REG_DISTORT_START]))))
    else $error("distortion start not in single pixels");

endmodule

// ---- rtl/sbp_pkg.sv ----
/*
  Shared constants for the binarizer parameter register bank: register
  indices, field positions, reset values and mode codes.
  Assumes the consuming modules reference every item as sbp_pkg::name.
*/
package sbp_pkg;

  // ****************************************************************
  // register indices on the 4-bit cpu address
  // ****************************************************************
  localparam logic [3:0] REG_CTRL0 = 4'h0;
  localparam logic [3:0] REG_CTRL1 = 4'h1;
  localparam logic [3:0] REG_CTRL2 = 4'h2;
  localparam logic [3:0] REG_CLAMP_START = 4'h3;
  localparam logic [3:0] REG_CLAMP_END = 4'h4;
  localparam logic [3:0] REG_DISTORT_START = 4'h5;
  localparam logic [3:0] REG_ABC_START = 4'h6;
  localparam logic [3:0] REG_ABC_END = 4'h7;
  localparam logic [3:0] REG_DATA_PORT = 4'h8;
  localparam logic [3:0] REG_REDUCE_DEN = 4'h9;
  localparam logic [3:0] REG_TRACK_SPEED = 4'hA;
  localparam logic [3:0] REG_BINARY = 4'hB;
  localparam logic [3:0] REG_EDGE = 4'hC;
  localparam logic [3:0] REG_SMOOTH = 4'hD;
  localparam logic [3:0] REG_CHAR = 4'hE;
  localparam logic [3:0] REG_DAC = 4'hF;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL0_SRAM_SEL = 5;
  localparam int CTRL0_WR_EN = 6;
  localparam int CTRL0_RD_EN = 7;
  localparam int CTRL2_BACK_EN = 7;
  localparam int BACK_EXP_EN = 5;
  localparam int BACK_EXP_DATA = 6;
  localparam int BACK_ALL_ADDR = 7;
  localparam int CHAR_APPLIED = 7;

  // ****************************************************************
  // reset values, codes and scaling
  // ****************************************************************
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] MODE_DITHER = 2'h2;
  localparam logic [1:0] MODE_DIFFUSION = 2'h3;
  localparam logic [2:0] SMOOTH_MAX = 3'h6;
  localparam int ABC_UNIT_SHIFT = 4;
  localparam logic [5:0] BG_RESET = 6'h20;

endpackage

// ---- rtl/sbp_port_router.sv ----
/*
  Routes host accesses on the address 8 data port to the adc result,
  the internal or the external line memory.
  Assumes strobes are single-cycle and synchronous to mclk.
*/
module sbp_port_router
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // access from the register bank
  input wire logic port_wr,
  input wire logic port_rd,
  input wire logic [7:0] port_wdata,
  input wire logic sram_sel,
  input wire logic wr_en,
  input wire logic rd_en,
  // memory strobes, registered
  output logic mem_wdata_q,
  output logic [7:0] mem_wdata,
  output logic int_mem_we,
  output logic ext_mem_we,
  output logic int_mem_re,
  output logic ext_mem_re,
  output logic adc_re
);

  typedef struct packed {
    logic [7:0] wdata;
    logic int_we;
    logic ext_we;
    logic int_re;
    logic ext_re;
    logic adc_re;
  } sbp_route_t;

  sbp_route_t st;
  sbp_route_t next_st;

  // pick one target per read and per enabled write; other registers are never touched here
  always_comb
  begin
    next_st = '0;
    next_st.wdata = st.wdata;
    if (port_wr && wr_en)
    begin
      next_st.wdata = port_wdata;
      next_st.int_we = sram_sel;
      next_st.ext_we = !sram_sel;
    end
    if (port_rd)
    begin
      next_st.int_re = rd_en && sram_sel;
      next_st.ext_re = rd_en && !sram_sel;
      next_st.adc_re = !rd_en; // without read enable the port shows the adc
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign mem_wdata_q = st.int_we | st.ext_we;
  assign mem_wdata = st.wdata;
  assign int_mem_we = st.int_we;
  assign ext_mem_we = st.ext_we;
  assign int_mem_re = st.int_re;
  assign ext_mem_re = st.ext_re;
  assign adc_re = st.adc_re;

endmodule

// ---- tb/scan_binarizer_param_regs_tb.sv ----
/*
  Self-checking bench for the binarizer parameter register bank: mode and
  enhancement decoding, expansion pin, selective reset, position windows,
  data port routing and the background tracker.
  Assumes sbp_param_regs as the top of the design, driven on falling mclk.
*/
// compares a design value with the bench's expectation and counts it
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module scan_binarizer_param_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic mclk = 1'b0;
  logic rst, dev_reset, cpu_wr, cpu_rd, pix_valid, line_mem_addr_msb;
  logic [3:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, adc_data, int_mem_rdata, ext_mem_rdata, mem_wdata;
  logic int_mem_we, ext_mem_we, int_mem_re, ext_mem_re, adc_re;
  logic [5:0] pix_level, slice_level, black_level, bg_level;
  logic [11:0] pix_count;
  logic [7:0] ctrl0, ctrl1, ctrl2, reduce_num, reduce_den, dac_data;
  logic mode_threshold, mode_dither, mode_diffusion, applied_binary, all_addr_access;
  logic [3:0] edge_h_strength, edge_v_strength, char_b_thr;
  logic [4:0] edge_corr_thr;
  logic [2:0] smooth_degree, char_a_strength;
  logic clamp_window, distort_active, abc_window, line_mem_addr_top_bit;
  int miscompares = 0;
  int cmp_count = 0;
  int cnt [5];
  logic [31:0] seed = 32'hA906;
  logic [7:0] b, c, d, e, s, en, ds, ab, ae, rv, dv;
  logic [1:0] m;
  logic [11:0] cl [12];
  logic [7:0] bk [4] = '{8'hE0, 8'h20, 8'hC0, 8'h00};
  wire [4:0] strb = {int_mem_we, ext_mem_we, int_mem_re, ext_mem_re, adc_re};

  // free-running clock, 8 ns period
  always #4 mclk = ~mclk;

  // strobe pulse counters, so "exactly one pulse" needs no exact cycle
  always @(posedge mclk)
    for (int i = 0; i < 5; i++) cnt[i] += int'(strb[i]);

  sbp_param_regs uut
  (
    .mclk, .rst, .dev_reset, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata,
    .adc_data, .int_mem_rdata, .ext_mem_rdata, .mem_wdata, .int_mem_we, .ext_mem_we,
    .int_mem_re, .ext_mem_re, .adc_re, .pix_valid, .pix_level, .pix_count, .line_mem_addr_msb,
    .ctrl0, .ctrl1, .ctrl2, .reduce_num, .reduce_den, .dac_data, .mode_threshold, .mode_dither,
    .mode_diffusion, .slice_level, .black_level, .edge_h_strength, .edge_v_strength,
    .edge_corr_thr, .smooth_degree, .char_b_thr, .char_a_strength, .applied_binary,
    .all_addr_access, .clamp_window, .distort_active, .abc_window, .bg_level,
    .line_mem_addr_top_bit
  );

  // ****************************************************************
  // expectations and helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [2:0] exp_smooth(input logic [7:0] v);
    return (v[7:5] == 3'h7) ? 3'h6 : v[7:5];
  endfunction

  // strobe order: int we, ext we, int re, ext re, adc re
  function automatic logic [4:0] exp_strobe(input logic w, input logic [7:0] c0);
    if (w)
      return c0[6] ? (c0[5] ? 5'h10 : 5'h08) : 5'h00;
    return c0[7] ? (c0[5] ? 5'h04 : 5'h02) : 5'h01;
  endfunction

  // all tasks are entered at a falling edge and leave at one
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    cpu_addr = a;
    cpu_wdata = v;
    cpu_wr = 1'b1;
    @(negedge mclk);
    cpu_wr = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge mclk);
    cpu_rd = 1'b0;
    @(negedge mclk);
    v = cpu_rdata;
  endtask

  // one data-port access under a given access select, then strobe and data check
  task automatic port(input logic w, input logic [7:0] c0, input logic [7:0] v);
    logic [7:0] got;
    logic [4:0] x;
    x = exp_strobe(w, c0);
    wr(4'h0, c0);
    adc_data = 8'(rnd());
    int_mem_rdata = 8'(rnd());
    ext_mem_rdata = 8'(rnd());
    foreach (cnt[i]) cnt[i] = 0;
    if (w)
      wr(4'h8, v);
    else
      rd(4'h8, got);
    repeat (2) @(negedge mclk);
    for (int i = 0; i < 5; i++) `CHK(cnt[i], int'(x[i]))
    if (w && c0[6]) `CHK(mem_wdata, v)
    if (w && !c0[6]) `CHK(reduce_num, v)
    if (!w) `CHK(got, c0[7] ? (c0[5] ? int_mem_rdata : ext_mem_rdata) : adc_data)
  endtask

  // a run of 32 valid pixels inside the tracking window at one speed setting
  task automatic trk(input logic [7:0] spd, input logic [5:0] lvl, input logic [5:0] want);
    wr(4'hA, spd);
    pix_level = lvl;
    pix_valid = 1'b1;
    repeat (32) @(negedge mclk);
    pix_valid = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK(bg_level, want)
  endtask

  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  // watchdog: a hang counts as a mismatch
  initial
  begin
    #400000;
    miscompares++;
    summarize();
  end

  initial
  begin
    rst = 1'b1;
    {dev_reset, cpu_wr, cpu_rd, pix_valid, line_mem_addr_msb} = 5'h00;
    {cpu_addr, cpu_wdata, adc_data, int_mem_rdata, ext_mem_rdata} = 36'h0;
    pix_level = 6'h00;
    pix_count = 12'h000;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    `CHK(bg_level, sbp_pkg::BG_RESET)
    `CHK(ctrl0, sbp_pkg::REG_RESET)
    // every mode code with random parameters, smoothing corner codes forced
    for (int i = 0; i < 16; i++)
    begin
      m = 2'(i >> 2);
      b = {m, 6'(rnd())};
      c = 8'(rnd());
      d = 8'(rnd());
      e = 8'(rnd());
      if (i[1:0] == 2'h0 || d[7:5] == 3'h7) d[7:5] = 3'h6; // host never programs seven
      if (i[1:0] == 2'h1) {d[7:5], c} = 11'h00F;
      wr(4'hB, b);
      wr(4'hC, c);
      wr(4'hD, d);
      wr(4'hE, e);
      `CHK({mode_threshold, mode_dither, mode_diffusion}, {m < 2'h2, m == 2'h2, m == 2'h3})
      `CHK(slice_level, (m < 2'h2) ? b[5:0] : 6'h00)
      `CHK(black_level, (m == 2'h3) ? b[5:0] : 6'h00)
      `CHK({edge_h_strength, edge_v_strength}, c)
      `CHK(edge_corr_thr, d[4:0])
      `CHK(smooth_degree, exp_smooth(d))
      `CHK(char_b_thr, m[1] ? e[3:0] : 4'h0)
      `CHK(char_a_strength, m[1] ? e[6:4] : 3'h0)
      `CHK(applied_binary, e[7])
    end
    // hand-written corners: dither code, diffusion black level, edges off
    wr(4'hB, 8'hA5);
    `CHK({mode_dither, mode_threshold, mode_diffusion}, 3'h4)
    wr(4'hB, 8'hE7);
    `CHK({black_level, slice_level}, {6'h27, 6'h00})
    wr(4'hC, 8'h00);
    `CHK({edge_h_strength, edge_v_strength}, 8'h00)
    // expansion pin: enabled follows data bit, disabled follows sequencer bit
    wr(4'hF, 8'h5A);
    wr(4'h2, 8'h80);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'hF, bk[i]);
      repeat (6)
      begin
        line_mem_addr_msb = 1'(rnd());
        @(negedge mclk);
        `CHK(line_mem_addr_top_bit, bk[i][5] ? bk[i][6] : line_mem_addr_msb)
        `CHK(all_addr_access, bk[i][7])
      end
    end
    `CHK(dac_data, 8'h5A)
    // selective reset clears 0..2 and the back register only
    dv = 8'(rnd());
    c = 8'(rnd());
    wr(4'h0, 8'(rnd()));
    wr(4'h1, 8'(rnd()) | 8'h01);
    wr(4'hF, 8'hE0);
    wr(4'h9, dv);
    wr(4'hC, c);
    dev_reset = 1'b1;
    @(negedge mclk);
    dev_reset = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK({ctrl0, ctrl1, ctrl2, all_addr_access, line_mem_addr_top_bit}, {25'h0, line_mem_addr_msb})
    `CHK({reduce_den, edge_h_strength, dac_data}, {dv, c[7:4], 8'h5A})
    // data port: writes and reads to every target, plus refused writes
    port(1'b1, 8'h40, 8'(rnd()));
    port(1'b1, 8'h60, 8'(rnd()));
    port(1'b1, 8'h00, 8'(rnd()));
    port(1'b1, 8'h20, 8'h00);
    port(1'b0, 8'h00, 8'h00);
    port(1'b0, 8'h80, 8'h00);
    port(1'b0, 8'hA0, 8'h00);
    rd(4'h0, rv);
    `CHK(rv, 8'hA0)
    rd(4'h3, rv);
    `CHK(rv, 8'h00)
    // position windows at their boundaries, random positions
    repeat (3)
    begin
      {s, en, ds, ab} = rnd();
      ae = 8'(rnd());
      wr(4'h3, s);
      wr(4'h4, en);
      wr(4'h5, ds);
      wr(4'h6, ab);
      wr(4'h7, ae);
      cl = '{{4'h0, s} - 12'h1, {4'h0, s}, {4'h0, en}, {4'h0, en} + 12'h1, {4'h0, ds} - 12'h1,
             {4'h0, ds}, {ab, 4'h0} - 12'h1, {ab, 4'h0}, {ae, 4'h0} - 12'h1, {ae, 4'h0},
             12'(rnd()), 12'(rnd())};
      foreach (cl[j])
      begin
        pix_count = cl[j];
        @(negedge mclk);
        `CHK(clamp_window, (cl[j] >= {4'h0, s}) && (cl[j] <= {4'h0, en}))
        `CHK(distort_active, cl[j] >= {4'h0, ds})
        `CHK(abc_window, (cl[j] >= {ab, 4'h0}) && (cl[j] < {ae, 4'h0}))
      end
    end
    // tracker: 32 pixels at speed k move the level by exactly k, and not at all when the pixel equals the level
    wr(4'h6, 8'h00);
    wr(4'h7, 8'hFF);
    pix_count = 12'd100;
    @(negedge mclk);
    trk(8'h0F, 6'h3F, 6'h20);
    trk(8'hF0, 6'h00, 6'h20);
    trk(8'h10, 6'h3F, 6'h21);
    trk(8'h0F, 6'h00, 6'h12);
    trk(8'hF1, 6'h3F, 6'h21);
    trk(8'hFF, 6'h21, 6'h21);
    summarize();
  end
endmodule
